// File: lcc_pkg.sv
// constants, field layouts and bus carrier of the configurable logic cell
// assumes a byte-wide register port on sys_clk and a synchronous active-low reset
`default_nettype none

package lcc_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W  = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_POLARITY = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_SRC_SEL0 = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_GATE_EN0 = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'ha;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hb;

  // control register fields
  localparam int unsigned CTL_EN_BIT   = 7;
  localparam int unsigned CTL_OUT_BIT  = 5;
  localparam int unsigned CTL_RISE_BIT = 4;
  localparam int unsigned CTL_FALL_BIT = 3;
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned MODE_W       = 3;

  // polarity register fields
  localparam int unsigned POLR_OUT_BIT  = 7;
  localparam int unsigned POLR_GATE_LSB = 0;

  // interrupt registers: bit 0 is the cell flag
  localparam int unsigned IRQ_CELL_BIT = 0;

  // reset values
  localparam logic [DATA_W-1:0] CONTROL_RST  = 8'h00;
  localparam logic              OUT_INV_RST  = 1'b0;
  localparam logic              IRQ_STAT_RST = 1'b0;
  localparam logic              IRQ_MASK_RST = 1'b0;

  typedef enum logic [MODE_W-1:0] {
    LCC_MODE_AND_OR   = 3'b000,
    LCC_MODE_OR_XOR   = 3'b001,
    LCC_MODE_AND4     = 3'b010,
    LCC_MODE_SR_LATCH = 3'b011,
    LCC_MODE_DFF_SR   = 3'b100,
    LCC_MODE_DFF2_R   = 3'b101,
    LCC_MODE_JK_R     = 3'b110,
    LCC_MODE_LATCH_SR = 3'b111
  } lcc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } lcc_bus_req_t;

endpackage : lcc_pkg

`default_nettype wire

// File: lcc_gate.sv
// one data gate of the logic cell: enable map, combine, output inversion
// assumes its data inputs are already synchronised to sys_clk
`default_nettype none

module lcc_gate (
  // selected data
  input  wire logic [3:0] data_i,
  // enable map, bit 2k+1 true and bit 2k negated of data k
  input  wire logic [7:0] enables_i,
  input  wire logic       invert_i,
  // gate result
  output logic            gate_o
);

  logic [7:0] terms;
  logic       combined;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      terms[2*k+1] = enables_i[2*k+1] & data_i[k];
      terms[2*k]   = enables_i[2*k] & ~data_i[k];
    end
  end

  // OR of enabled terms: with negated inputs and inversion it is the AND form,
  // and an empty map gives zero before inversion
  assign combined = |terms;
  assign gate_o   = combined ^ invert_i;

endmodule // lcc_gate

`default_nettype wire

// File: lcc_top.sv
// configurable logic cell: register port, source selects, gates, functions,
// output inversion and edge interrupt
// assumes source inputs are asynchronous to sys_clk; one master on the port
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`default_nettype none

module lcc_top #(
  parameter int unsigned NUM_SRC = 64
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_n_i,
  // register port
  input  wire lcc_pkg::lcc_bus_req_t bus_req_i,
  output logic [lcc_pkg::DATA_W-1:0] rd_data_o,
  // selectable sources from pins and peripherals
  input  wire logic [NUM_SRC-1:0]   src_i,
  // cell output and interrupt
  output logic                      cell_out_o,
  output logic                      irq_o
);

  generate
    if (NUM_SRC < 1 || NUM_SRC > (1 << lcc_pkg::SEL_W)) begin : g_bad_src
      $error("NUM_SRC must lie between 1 and 64");
    end
  endgenerate

  // control register
  logic                        en_reg;
  logic                        rise_en_reg;
  logic                        fall_en_reg;
  lcc_pkg::lcc_mode_t          mode_reg;
  // polarity register
  logic                        out_inv_reg;
  logic [3:0]                  gate_inv_reg;
  // selects and gate enables
  logic [lcc_pkg::SEL_W-1:0]   src_sel_reg [4];
  logic [7:0]                  gate_en_reg [4];
  // interrupt
  logic                        irq_stat_reg;
  logic                        irq_mask_reg;
  // datapath
  logic [NUM_SRC-1:0]          src_meta_reg;
  logic [NUM_SRC-1:0]          src_sync_reg;
  logic [3:0]                  data_sel;
  logic [3:0]                  gate_out;
  logic                        g1_prev_reg;
  logic                        q_reg;
  logic                        q_next;
  logic                        func_out;
  logic                        cell_out_reg;
  logic                        out_prev_reg;
  logic                        rise_evt;
  logic                        fall_evt;
  logic                        irq_reg;
  logic [lcc_pkg::DATA_W-1:0]  rd_data_reg;
  logic [lcc_pkg::DATA_W-1:0]  rd_mux;

  // source mux; an index past the implemented sources reads zero
  function automatic logic pick_src(input logic [NUM_SRC-1:0]        srcs,
                                    input logic [lcc_pkg::SEL_W-1:0] sel);
    logic bit_v;
    bit_v = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (sel == i[lcc_pkg::SEL_W-1:0]) begin
        bit_v = srcs[i];
      end
    end
    return bit_v;
  endfunction

  // register index decode shared by the four select and four gate banks
  function automatic logic hits(input logic [lcc_pkg::ADDR_W-1:0] addr,
                                input logic [lcc_pkg::ADDR_W-1:0] base,
                                input int unsigned                idx);
    return addr == (base + idx[lcc_pkg::ADDR_W-1:0]);
  endfunction

  logic wr_ctl;
  logic wr_pol;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctl  = bus_req_i.wr && (bus_req_i.addr == lcc_pkg::OFS_CONTROL);
  assign wr_pol  = bus_req_i.wr && (bus_req_i.addr == lcc_pkg::OFS_POLARITY);
  assign wr_stat = bus_req_i.wr && (bus_req_i.addr == lcc_pkg::OFS_IRQ_STAT);
  assign wr_mask = bus_req_i.wr && (bus_req_i.addr == lcc_pkg::OFS_IRQ_MASK);

  // control register: cleared by reset, as are the output inversion and the interrupt mask
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_reg      <= lcc_pkg::CONTROL_RST[lcc_pkg::CTL_EN_BIT];
      rise_en_reg <= lcc_pkg::CONTROL_RST[lcc_pkg::CTL_RISE_BIT];
      fall_en_reg <= lcc_pkg::CONTROL_RST[lcc_pkg::CTL_FALL_BIT];
      mode_reg    <= lcc_pkg::lcc_mode_t'(lcc_pkg::CONTROL_RST[lcc_pkg::MODE_W-1:0]);
    end else if (wr_ctl) begin
      // bits 6 and 5 are not stored: unused and read-only
      en_reg      <= bus_req_i.wdata[lcc_pkg::CTL_EN_BIT];
      rise_en_reg <= bus_req_i.wdata[lcc_pkg::CTL_RISE_BIT];
      fall_en_reg <= bus_req_i.wdata[lcc_pkg::CTL_FALL_BIT];
      mode_reg    <= lcc_pkg::lcc_mode_t'(
                     bus_req_i.wdata[lcc_pkg::CTL_MODE_LSB +: lcc_pkg::MODE_W]);
    end
  end

  // output inversion has a defined reset value; gate inversions survive reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      out_inv_reg <= lcc_pkg::OUT_INV_RST;
    end else if (wr_pol) begin
      out_inv_reg <= bus_req_i.wdata[lcc_pkg::POLR_OUT_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (wr_pol) begin
      gate_inv_reg <= bus_req_i.wdata[lcc_pkg::POLR_GATE_LSB +: 4];
    end
  end

  // selects and gate maps carry no reset: software sets them before enabling
  always_ff @(posedge sys_clk_i) begin
    for (int k = 0; k < 4; k++) begin
      if (bus_req_i.wr && hits(bus_req_i.addr, lcc_pkg::OFS_SRC_SEL0, k)) begin
        src_sel_reg[k] <= bus_req_i.wdata[lcc_pkg::SEL_W-1:0];
      end
      if (bus_req_i.wr && hits(bus_req_i.addr, lcc_pkg::OFS_GATE_EN0, k)) begin
        gate_en_reg[k] <= bus_req_i.wdata;
      end
    end
  end

  // two-stage synchroniser for the asynchronous sources
  always_ff @(posedge sys_clk_i) begin
    src_meta_reg <= src_i;
    src_sync_reg <= src_meta_reg;
  end

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      data_sel[k] = pick_src(src_sync_reg, src_sel_reg[k]);
    end
  end

  generate
    for (genvar k = 0; k < 4; k++) begin : g_gate
      lcc_gate u_gate (
        .data_i    (data_sel),
        .enables_i (gate_en_reg[k]),
        .invert_i  (gate_inv_reg[k]),
        .gate_o    (gate_out[k])
      );
    end
  endgenerate

  // gate 1 is the clock of the flop modes; its rising edge is seen on sys_clk
  logic g1_rise;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      g1_prev_reg <= 1'b0;
    end else begin
      g1_prev_reg <= gate_out[0];
    end
  end

  assign g1_rise = gate_out[0] & ~g1_prev_reg;

  // logic function; storage modes work on sys_clk samples, so pulses on
  // gates shorter than one period may be missed
  always_comb begin
    q_next   = q_reg;
    func_out = 1'b0;
    unique case (mode_reg)
      lcc_pkg::LCC_MODE_AND_OR: begin
        func_out = (gate_out[0] & gate_out[1]) | (gate_out[2] & gate_out[3]);
      end
      lcc_pkg::LCC_MODE_OR_XOR: begin
        func_out = (gate_out[0] | gate_out[1]) ^ (gate_out[2] | gate_out[3]);
      end
      lcc_pkg::LCC_MODE_AND4: begin
        func_out = &gate_out;
      end
      lcc_pkg::LCC_MODE_SR_LATCH: begin
        // set = g1|g2, reset = g3|g4, set wins
        if (gate_out[0] | gate_out[1]) begin
          q_next = 1'b1;
        end else if (gate_out[2] | gate_out[3]) begin
          q_next = 1'b0;
        end
        func_out = q_next;
      end
      lcc_pkg::LCC_MODE_DFF_SR: begin
        // clock g1, data g2, reset g3 (dominant), set g4
        if (gate_out[2]) begin
          q_next = 1'b0;
        end else if (gate_out[3]) begin
          q_next = 1'b1;
        end else if (g1_rise) begin
          q_next = gate_out[1];
        end
        func_out = q_next;
      end
      lcc_pkg::LCC_MODE_DFF2_R: begin
        // clock g1, data g2 & g4, reset g3
        if (gate_out[2]) begin
          q_next = 1'b0;
        end else if (g1_rise) begin
          q_next = gate_out[1] & gate_out[3];
        end
        func_out = q_next;
      end
      lcc_pkg::LCC_MODE_JK_R: begin
        // clock g1, J g2, K g4, reset g3
        if (gate_out[2]) begin
          q_next = 1'b0;
        end else if (g1_rise) begin
          unique case ({gate_out[1], gate_out[3]})
            2'b00: q_next = q_reg;
            2'b01: q_next = 1'b0;
            2'b10: q_next = 1'b1;
            2'b11: q_next = ~q_reg;
          endcase
        end
        func_out = q_next;
      end
      lcc_pkg::LCC_MODE_LATCH_SR: begin
        // enable g1 (transparent while high), data g2, reset g3, set g4
        if (gate_out[2]) begin
          q_next = 1'b0;
        end else if (gate_out[3]) begin
          q_next = 1'b1;
        end else if (gate_out[0]) begin
          q_next = gate_out[1];
        end
        func_out = q_next;
      end
    endcase
  end

  // storage is held cleared while disabled so re-enabling starts from zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !en_reg) begin
      q_reg <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  // cell output: forced low while disabled, inverted last
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cell_out_reg <= 1'b0;
    end else if (!en_reg) begin
      cell_out_reg <= 1'b0;
    end else begin
      cell_out_reg <= func_out ^ out_inv_reg;
    end
  end

  // edge detectors on the final output; an inversion change is an edge too
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      out_prev_reg <= 1'b0;
    end else begin
      out_prev_reg <= cell_out_reg;
    end
  end

  assign rise_evt = rise_en_reg &  cell_out_reg & ~out_prev_reg;
  assign fall_evt = fall_en_reg & ~cell_out_reg &  out_prev_reg;

  // sticky flag, write one to clear; a new edge beats the clear
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_stat_reg <= lcc_pkg::IRQ_STAT_RST;
    end else if (rise_evt || fall_evt) begin
      irq_stat_reg <= 1'b1;
    end else if (wr_stat && bus_req_i.wdata[lcc_pkg::IRQ_CELL_BIT]) begin
      irq_stat_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_mask_reg <= lcc_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= bus_req_i.wdata[lcc_pkg::IRQ_CELL_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_stat_reg & irq_mask_reg;
    end
  end

  // read mux; unused and unmapped bits read zero
  always_comb begin
    rd_mux = 8'h00;
    if (bus_req_i.addr == lcc_pkg::OFS_CONTROL) begin
      rd_mux[lcc_pkg::CTL_EN_BIT]   = en_reg;
      rd_mux[lcc_pkg::CTL_OUT_BIT]  = cell_out_reg;
      rd_mux[lcc_pkg::CTL_RISE_BIT] = rise_en_reg;
      rd_mux[lcc_pkg::CTL_FALL_BIT] = fall_en_reg;
      rd_mux[lcc_pkg::CTL_MODE_LSB +: lcc_pkg::MODE_W] = mode_reg;
    end else if (bus_req_i.addr == lcc_pkg::OFS_POLARITY) begin
      rd_mux[lcc_pkg::POLR_OUT_BIT]       = out_inv_reg;
      rd_mux[lcc_pkg::POLR_GATE_LSB +: 4] = gate_inv_reg;
    end else if (bus_req_i.addr == lcc_pkg::OFS_IRQ_STAT) begin
      rd_mux[lcc_pkg::IRQ_CELL_BIT] = irq_stat_reg;
    end else if (bus_req_i.addr == lcc_pkg::OFS_IRQ_MASK) begin
      rd_mux[lcc_pkg::IRQ_CELL_BIT] = irq_mask_reg;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (hits(bus_req_i.addr, lcc_pkg::OFS_SRC_SEL0, k)) begin
          rd_mux[lcc_pkg::SEL_W-1:0] = src_sel_reg[k];
        end
        if (hits(bus_req_i.addr, lcc_pkg::OFS_GATE_EN0, k)) begin
          rd_mux = gate_en_reg[k];
        end
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= 8'h00;
    end else if (bus_req_i.rd) begin
      rd_data_reg <= rd_mux;
    end else begin
      rd_data_reg <= 8'h00;
    end
  end

  assign rd_data_o  = rd_data_reg;
  assign cell_out_o = cell_out_reg;
  assign irq_o      = irq_reg;

endmodule // lcc_top

`default_nettype wire

// File: lcc_props.sv
// concurrent checks on the logic cell ports
// assumes one clock domain, synchronous active-low reset, bound into lcc_top
`default_nettype none

module lcc_props #(
  parameter int unsigned NUM_SRC = 64
) (
  // clock and reset
  input wire logic                       sys_clk_i,
  input wire logic                       rst_n_i,
  // register port
  input wire lcc_pkg::lcc_bus_req_t      bus_req_i,
  input wire logic [lcc_pkg::DATA_W-1:0] rd_data_o,
  // sources and results
  input wire logic [NUM_SRC-1:0]         src_i,
  input wire logic                       cell_out_o,
  input wire logic                       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic en_q;
  logic rise_q;
  logic fall_q;
  logic mask_q;
  logic rd_ctl;
  logic rd_pol;
  logic rd_sel;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  assign rd_ctl = bus_req_i.rd && bus_req_i.addr == lcc_pkg::OFS_CONTROL;
  assign rd_pol = bus_req_i.rd && bus_req_i.addr == lcc_pkg::OFS_POLARITY;
  assign rd_sel = bus_req_i.rd && bus_req_i.addr >= lcc_pkg::OFS_SRC_SEL0
                  && bus_req_i.addr < lcc_pkg::OFS_GATE_EN0;

  // shadow of the control and mask bits the edge checks depend on
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      en_q   <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      mask_q <= 1'b0;
    end else if (bus_req_i.wr) begin
      if (bus_req_i.addr == lcc_pkg::OFS_CONTROL) begin
        en_q   <= bus_req_i.wdata[lcc_pkg::CTL_EN_BIT];
        rise_q <= bus_req_i.wdata[lcc_pkg::CTL_RISE_BIT];
        fall_q <= bus_req_i.wdata[lcc_pkg::CTL_FALL_BIT];
      end
      if (bus_req_i.addr == lcc_pkg::OFS_IRQ_MASK) begin
        mask_q <= bus_req_i.wdata[lcc_pkg::IRQ_CELL_BIT];
      end
    end
  end

  sequence s_rise_seen;
    $rose(cell_out_o) && rise_q && mask_q;
  endsequence
  sequence s_fall_seen;
    $fell(cell_out_o) && fall_q && mask_q;
  endsequence

  a_rd_idle_zero: assert property (!$past(bus_req_i.rd) |-> rd_data_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctl_gap_zero: assert property ($past(rd_ctl) |-> rd_data_o[6] == 1'b0)
    else $error("control bit 6 reads one");
  a_pol_gap_zero: assert property ($past(rd_pol) |-> rd_data_o[6:4] == 3'h0)
    else $error("polarity bits 6..4 read nonzero");
  a_sel_top_zero: assert property ($past(rd_sel) |-> rd_data_o[7:6] == 2'h0)
    else $error("source select upper bits read nonzero");
  a_out_mirror: assert property ($past(rd_ctl) && $stable(cell_out_o)
                                 |-> rd_data_o[5] == cell_out_o)
    else $error("control output bit differs from cell output");
  a_off_out_low: assert property (!en_q |=> !cell_out_o)
    else $error("cell output high while disabled");
  a_irq_needs_mask: assert property (irq_o |-> $past(mask_q))
    else $error("interrupt high with mask clear");
  a_rise_sets_irq: assert property (s_rise_seen |-> ##2 irq_o)
    else $error("rising edge did not raise the interrupt");
  a_fall_sets_irq: assert property (s_fall_seen |-> ##2 irq_o)
    else $error("falling edge did not raise the interrupt");
  a_reset_quiet: assert property ($rose(rst_n_i)
                                  |-> rd_data_o == 8'h00 && !cell_out_o && !irq_o)
    else $error("outputs not quiet after reset");

endmodule : lcc_props

bind lcc_top lcc_props #(.NUM_SRC(NUM_SRC)) u_props (
  .sys_clk_i (sys_clk_i),
  .rst_n_i   (rst_n_i),
  .bus_req_i (bus_req_i),
  .rd_data_o (rd_data_o),
  .src_i     (src_i),
  .cell_out_o(cell_out_o),
  .irq_o     (irq_o)
);

`default_nettype wire

// File: lcc_src_model.sv
// behavioural pins and peripherals feeding the cell sources
// assumes the bench commands the four low sources; the rest are unselected
`default_nettype none

module lcc_src_model #(
  parameter int unsigned NUM_SRC = 64
) (
  // clock and commanded levels of the four low sources
  input  wire logic               sys_clk_i,
  input  wire logic [3:0]         level_i,
  // full source vector into the cell
  output var  logic [NUM_SRC-1:0] src_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial src_o = '0;
  // unused sources toggle so nothing relies on a settled value
  always @(posedge sys_clk_i) begin
    src_o <= {~src_o[NUM_SRC-1:4], level_i};
  end
endmodule : lcc_src_model

`default_nettype wire

// File: tb_configurable_logic_cell_control.sv
// self-checking bench of the logic cell through its register port
// assumes lcc_top, lcc_props and lcc_src_model are compiled before it
`default_nettype none

module tb_configurable_logic_cell_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  sys_clk_i;
  logic                  rst_n_i;
  lcc_pkg::lcc_bus_req_t req;
  logic [7:0]            rd_data;
  logic [63:0]           src;
  logic [3:0]            lvl;
  logic                  cell_out;
  logic                  irq;
  int                    failures = 0;
  int                    total_checks = 0;

  // control byte, polarity, gate1..4 enables
  localparam logic [47:0] COMB [7] = '{48'h02_00_02_08_20_80, 48'h00_00_02_08_20_80,
    48'h01_00_02_08_20_80, 48'h02_80_02_08_20_80, 48'h02_05_02_08_20_80,
    48'h02_0a_06_08_20_80, 48'h02_0f_55_00_00_00};
  // mode, source levels, expected output
  localparam logic [11:0] SEQ [34] = '{12'h400, 12'h420, 12'h431, 12'h411, 12'h401,
    12'h410, 12'h481, 12'h401, 12'h440, 12'h640, 12'h620, 12'h631, 12'h681, 12'h690,
    12'h6a0, 12'h6b1, 12'h6a1, 12'h6b0, 12'h311, 12'h301, 12'h340, 12'h300, 12'h321,
    12'h731, 12'h710, 12'h700, 12'h720, 12'h731, 12'h721, 12'h540, 12'h5a0, 12'h5b1,
    12'h521, 12'h530};
  localparam logic [7:0] REGS [16] = '{8'h1f, 8'h8f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h7f,
    8'h7f, 8'h7f, 8'h7f, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  lcc_top #(.NUM_SRC(64)) dut_u (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .bus_req_i (req),
    .rd_data_o (rd_data),
    .src_i     (src),
    .cell_out_o(cell_out),
    .irq_o     (irq)
  );

  lcc_src_model #(.NUM_SRC(64)) src_u (
    .sys_clk_i(sys_clk_i),
    .level_i  (lvl),
    .src_o    (src)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w, input logic r);
    @(posedge sys_clk_i);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge sys_clk_i);
    req <= '0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, d, 1'b1, 1'b0);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    bus(a, 8'h00, 1'b0, 1'b1);
    #1 chk(rd_data & m, exp);
  endtask

  task automatic settle(input logic [1:0] e);
    repeat (6) @(posedge sys_clk_i);
    #1 chk({6'h0, cell_out, irq}, {6'h0, e});
  endtask

  task automatic pulse_reset;
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask

  // disabling first clears the function storage between setups
  task automatic cfg(input logic [47:0] c);
    wr(lcc_pkg::OFS_CONTROL, 8'h00);
    wr(lcc_pkg::OFS_POLARITY, c[39:32]);
    for (int k = 0; k < 4; k++) wr(lcc_pkg::OFS_GATE_EN0 + 4'(k), c[8*(3-k) +: 8]);
    wr(lcc_pkg::OFS_CONTROL, 8'h80 | c[47:40]);
  endtask

  function automatic logic gate_f(input logic [7:0] en, input logic [3:0] d, input logic inv);
    logic [7:0] t;
    t = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
    return (|(en & t)) ^ inv;
  endfunction

  function automatic logic comb_f(input logic [47:0] c, input logic [3:0] d);
    logic [3:0] g;
    logic       r;
    for (int k = 0; k < 4; k++) g[k] = gate_f(c[8*(3-k) +: 8], d, c[32+k]);
    case (c[42:40])
      3'd0: r = (g[0] & g[1]) | (g[2] & g[3]);
      3'd1: r = (g[0] | g[1]) ^ (g[2] | g[3]);
      default: r = &g;
    endcase
    return r ^ c[39];
  endfunction

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    failures++;
    close_out();
  end

  initial begin
    rst_n_i = 1'b0;
    req = '0;
    lvl = 4'h0;
    pulse_reset();
    for (int a = 0; a < 16; a++) wr(4'(a), (a == 1) ? 8'hff : 8'h7f);
    for (int a = 0; a < 16; a++) rdc(4'(a), REGS[a], 8'hff);
    @(posedge sys_clk_i);
    pulse_reset();
    for (int a = 0; a < 16; a++) begin
      rdc(4'(a), (a == 0 || a == 11) ? 8'h00 : REGS[a] & 8'h7f, 8'hff);
    end
    $display("test registers done");
    for (int k = 0; k < 4; k++) wr(lcc_pkg::OFS_SRC_SEL0 + 4'(k), 8'(k));
    foreach (COMB[i]) begin
      cfg(COMB[i]);
      for (int s = 0; s < 16; s++) begin
        @(posedge sys_clk_i) lvl <= 4'(s);
        settle({comb_f(COMB[i], 4'(s)), 1'b0});
      end
    end
    $display("test combinational done");
    foreach (SEQ[i]) begin
      if (i == 0 || SEQ[i][11:8] != SEQ[i-1][11:8]) cfg({5'h0, SEQ[i][10:8], 40'h00_02_08_20_80});
      @(posedge sys_clk_i) lvl <= SEQ[i][7:4];
      settle({SEQ[i][0], 1'b0});
    end
    $display("test sequential done");
    wr(lcc_pkg::OFS_IRQ_MASK, 8'h01);
    cfg(48'h12_0f_00_00_00_00);
    settle(2'b11);
    rdc(lcc_pkg::OFS_CONTROL, 8'hb2, 8'hff);
    wr(lcc_pkg::OFS_IRQ_STAT, 8'h01);
    settle(2'b10);
    wr(lcc_pkg::OFS_POLARITY, 8'h8f);
    settle(2'b00);
    rdc(lcc_pkg::OFS_IRQ_STAT, 8'h00, 8'hff);
    wr(lcc_pkg::OFS_CONTROL, 8'h8a);
    wr(lcc_pkg::OFS_POLARITY, 8'h0f);
    settle(2'b10);
    rdc(lcc_pkg::OFS_IRQ_STAT, 8'h00, 8'hff);
    wr(lcc_pkg::OFS_POLARITY, 8'h8f);
    settle(2'b01);
    wr(lcc_pkg::OFS_IRQ_MASK, 8'h00);
    settle(2'b00);
    rdc(lcc_pkg::OFS_IRQ_STAT, 8'h01, 8'hff);
    // the clear write is taken in the very cycle the falling edge is flagged
    wr(lcc_pkg::OFS_IRQ_STAT, 8'h01);
    wr(lcc_pkg::OFS_POLARITY, 8'h0f);
    wr(lcc_pkg::OFS_POLARITY, 8'h8f);
    wr(lcc_pkg::OFS_IRQ_STAT, 8'h01);
    rdc(lcc_pkg::OFS_IRQ_STAT, 8'h01, 8'hff);
    wr(lcc_pkg::OFS_IRQ_STAT, 8'h01);
    rdc(lcc_pkg::OFS_IRQ_STAT, 8'h00, 8'hff);
    $display("test interrupt done");
    close_out();
  end
endmodule : tb_configurable_logic_cell_control

`default_nettype wire
